// ===== sep_map.svh
// Constants of the two-wire serial memory slave: field positions,
// reset values and timing counts.
// Assumes inclusion by bare name from the design files.
`ifndef SEP_MAP_SVH
`define SEP_MAP_SVH

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define SEP_CLK_FREQ_MHZ 200
// Self-timed program duration in microseconds, plain default
`define SEP_PROG_TIME_US 5000
`define SEP_PROG_CYCLES (`SEP_PROG_TIME_US * `SEP_CLK_FREQ_MHZ)

// ---------------------------------------------------------------
// Slave address and array layout
// ---------------------------------------------------------------
// Device type code default, value arbitrary
`define SEP_TYPE_CODE_DEF 4'h5
`define SEP_SA_TYPE_MSB 7
`define SEP_SA_TYPE_LSB 4
`define SEP_SA_SEL_MSB 3
`define SEP_SA_SEL_LSB 1
`define SEP_SA_DIR_BIT 0
`define SEP_ADDR_W 8
`define SEP_PAGE_W 4
`define SEP_PAGE_BYTES 16
`define SEP_UPPER_BIT 7
`define SEP_ERASED 8'hff

// ---------------------------------------------------------------
// Bit counter positions within a nine-clock byte slot
// ---------------------------------------------------------------
`define SEP_LAST_DATA_BIT 4'h7
`define SEP_ACK_SLOT 4'h8

`endif

// ===== sep_pkg.sv
// Types shared by the two-wire serial memory slave.
// Assumes nothing of its surroundings.
package sep_pkg;

  // Protocol state of the slave
  typedef enum logic [2:0] {
    SEP_IDLE,
    SEP_DEV_ADDR,
    SEP_WORD_ADDR,
    SEP_WR_DATA,
    SEP_RD_DATA,
    SEP_IGNORE
  } sep_state_e;

endpackage

// ===== sep_link_rx.sv
// Link-side bit capture, clocked by the serial clock itself.
// Assumes the serial clock stands still between frames; each rising
// edge captures one data bit and flips a toggle for the core.
`timescale 1ns/100ps

module sep_link_rx (
  // Link clock and reset
  input wire logic i_scl,
  input wire logic i_rst,
  // Serial data level
  input wire logic i_sda,
  // Captured bit and arrival toggle
  output logic o_bit,
  output logic o_tog
);

  // ---------------------------------------------------------------
  // Capture on rising serial clock
  // ---------------------------------------------------------------
  // Bit stays stable until the next rising edge
  always_ff @(posedge i_scl or posedge i_rst) begin
    if (i_rst) begin
      o_bit <= 1'b0;
      o_tog <= 1'b0;
    end else begin
      o_bit <= i_sda;
      o_tog <= ~o_tog;
    end
  end

endmodule

// ===== sep_core.sv
// Two-wire serial slave front end of a 2 Kbit byte-addressed memory.
// Assumes an open-drain data line resolved outside, a master that
// drives the serial clock, and strap and protect pins that are static.
// Functional notes
// - Data changes only while clock low
// - Start/stop framing; ignore until start seen
// - Top four address bits must match type
// - Three select bits must match strap pins
// - Last address bit selects read or write
// - Acknowledge a matching slave address
// - Write: word address then data, both acknowledged
// - Stop after write starts timed program, bus ignored
// - Page write of up to sixteen bytes
// - Page address wraps inside its page
// - Page write may start anywhere in page
// - Acknowledge each data byte, advance counter
// - No acknowledge while programming; polling allowed
// - Protected upper half: data not acknowledged
// - Current read uses last address plus one
// - Single read ends on master nack, stop
// - Sequential read continues on each master ack
// - Read counter wraps across whole array
`timescale 1ns/100ps
`include "sep_map.svh"

module sep_core
  import sep_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = `SEP_PROG_CYCLES,
  // Device type code, value arbitrary
  parameter logic [3:0] TYPE_CODE = `SEP_TYPE_CODE_DEF
) (
  // System clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Serial link
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  // Straps and protection
  input wire logic i_select_strap_bit0,
  input wire logic i_select_strap_bit1,
  input wire logic i_select_strap_bit2,
  input wire logic i_wp,
  // Status
  output logic o_busy
);

  localparam int CNT_W = $clog2(PROG_CYCLES + 1);
  localparam logic [CNT_W-1:0] PROG_LAST = CNT_W'(PROG_CYCLES - 1);
  localparam logic [CNT_W-1:0] PAGE_CNT = CNT_W'(`SEP_PAGE_BYTES);
  localparam int AW = `SEP_ADDR_W;
  localparam int PW = `SEP_PAGE_W;

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic scl_s1_reg, scl_s2_reg, scl_s3_reg;
  logic sda_s1_reg, sda_s2_reg, sda_s3_reg;
  logic tog_s1_reg, tog_s2_reg, tog_s3_reg;
  logic wp_s1_reg, wp_s2_reg;
  logic [2:0] sel_s1_reg, sel_s2_reg;
  logic link_bit, link_tog;
  sep_state_e state_reg, state_next;
  logic [3:0] bitcnt_reg;
  logic [7:0] shift_reg;
  logic ack_pend_reg;
  logic [AW-1:0] addr_reg;
  logic [7:0] tx_reg;
  logic busy_reg;
  logic [CNT_W-1:0] prog_cnt_reg;
  logic [`SEP_PAGE_BYTES-1:0] mask_reg;
  logic [7:0] page_buf [`SEP_PAGE_BYTES];
  logic [7:0] mem [2**AW];

  // ---------------------------------------------------------------
  // Link-clock bit capture
  // ---------------------------------------------------------------
  sep_link_rx u_link_rx (
    .i_scl(i_scl),
    .i_rst(i_rst),
    .i_sda(i_sda),
    .o_bit(link_bit),
    .o_tog(link_tog)
  );

  // ---------------------------------------------------------------
  // Synchronisers
  // ---------------------------------------------------------------
  // Pins and the link toggle pass two flops; third stage finds edges
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      {scl_s1_reg, scl_s2_reg, scl_s3_reg} <= 3'h7;
      {sda_s1_reg, sda_s2_reg, sda_s3_reg} <= 3'h7;
      {tog_s1_reg, tog_s2_reg, tog_s3_reg} <= 3'h0;
      {wp_s1_reg, wp_s2_reg} <= 2'h0;
      sel_s1_reg <= 3'h0;
      sel_s2_reg <= 3'h0;
    end else begin
      {scl_s1_reg, scl_s2_reg, scl_s3_reg} <=
        {i_scl, scl_s1_reg, scl_s2_reg};
      {sda_s1_reg, sda_s2_reg, sda_s3_reg} <=
        {i_sda, sda_s1_reg, sda_s2_reg};
      {tog_s1_reg, tog_s2_reg, tog_s3_reg} <=
        {link_tog, tog_s1_reg, tog_s2_reg};
      {wp_s1_reg, wp_s2_reg} <= {i_wp, wp_s1_reg};
      sel_s1_reg <= {i_select_strap_bit2, i_select_strap_bit1,
                     i_select_strap_bit0};
      sel_s2_reg <= sel_s1_reg;
    end
  end

  // ---------------------------------------------------------------
  // Bus events and decodes
  // ---------------------------------------------------------------
  // Data edge with clock high is framing, never data
  wire scl_high = scl_s2_reg & scl_s3_reg;
  wire scl_fall = scl_s3_reg & ~scl_s2_reg;
  wire start_ev = scl_high & sda_s3_reg & ~sda_s2_reg;
  wire stop_ev = scl_high & ~sda_s3_reg & sda_s2_reg;
  // Captured bit is stable for a whole clock period after the toggle
  wire bit_ev = tog_s2_reg ^ tog_s3_reg;
  wire active = (state_reg != SEP_IDLE) && (state_reg != SEP_IGNORE);
  wire bit_go = bit_ev & ~start_ev & ~stop_ev & active;
  wire last_bit = bit_go & (bitcnt_reg == `SEP_LAST_DATA_BIT);
  wire ack_bit = bit_go & (bitcnt_reg == `SEP_ACK_SLOT);
  wire [7:0] rx_byte = {shift_reg[6:0], link_bit};
  wire type_ok =
    rx_byte[`SEP_SA_TYPE_MSB:`SEP_SA_TYPE_LSB] == TYPE_CODE;
  wire sel_ok =
    rx_byte[`SEP_SA_SEL_MSB:`SEP_SA_SEL_LSB] == sel_s2_reg;
  wire addr_hit = type_ok & sel_ok & ~busy_reg;
  wire dir_read = rx_byte[`SEP_SA_DIR_BIT];
  wire wp_block = wp_s2_reg & addr_reg[`SEP_UPPER_BIT];
  wire take_dev = last_bit & (state_reg == SEP_DEV_ADDR);
  wire take_word = last_bit & (state_reg == SEP_WORD_ADDR);
  wire take_data = last_bit & (state_reg == SEP_WR_DATA);
  wire data_ok = ~wp_block;
  wire in_rd = state_reg == SEP_RD_DATA;
  wire rd_more = ack_bit & in_rd & ~ack_pend_reg & ~link_bit;
  wire rd_stop = ack_bit & in_rd & ~ack_pend_reg & link_bit;
  wire rd_first = take_dev & addr_hit & dir_read;
  wire load_tx = rd_first | rd_more;
  wire ack_want = (take_dev & addr_hit) | take_word |
                  (take_data & data_ok);
  // Page address: low bits step, page bits hold
  wire [AW-1:0] page_next =
    {addr_reg[AW-1:PW], addr_reg[PW-1:0] + 1'b1};
  wire [7:0] mem_rd = mem[addr_reg];
  wire tx_bit = tx_reg[3'h7 - bitcnt_reg[2:0]];
  // Drive low only for our acknowledge or a zero read bit
  wire drive_low = ack_pend_reg |
    (in_rd & ~bitcnt_reg[3] & ~tx_bit);
  wire prog_go = stop_ev & (state_reg == SEP_WR_DATA) & (|mask_reg) &
                 ~busy_reg;
  wire [PW-1:0] commit_idx = prog_cnt_reg[PW-1:0];
  wire commit_we = busy_reg & (prog_cnt_reg < PAGE_CNT) &
                   mask_reg[commit_idx];
  wire [AW-1:0] commit_addr = {addr_reg[AW-1:PW], commit_idx};

  // ---------------------------------------------------------------
  // Protocol state machine
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    if (stop_ev) begin
      state_next = SEP_IDLE;
    end else if (start_ev) begin
      state_next = SEP_DEV_ADDR;
    end else begin
      unique case (state_reg)
        SEP_IDLE, SEP_IGNORE: begin
          state_next = state_reg;
        end
        SEP_DEV_ADDR: begin
          if (take_dev && !addr_hit) begin
            state_next = SEP_IGNORE;
          end else if (take_dev) begin
            state_next = dir_read ? SEP_RD_DATA : SEP_WORD_ADDR;
          end
        end
        SEP_WORD_ADDR: begin
          if (take_word) begin
            state_next = SEP_WR_DATA;
          end
        end
        SEP_WR_DATA: begin
          if (take_data && !data_ok) begin
            state_next = SEP_IGNORE;
          end
        end
        SEP_RD_DATA: begin
          if (rd_stop) begin
            state_next = SEP_IGNORE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= SEP_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------
  // Bit counter, shift and acknowledge
  // ---------------------------------------------------------------
  // Nine clocks per byte: eight bits then the acknowledge slot
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      bitcnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ack_pend_reg <= 1'b0;
    end else if (start_ev || stop_ev) begin
      bitcnt_reg <= 4'h0;
      ack_pend_reg <= 1'b0;
    end else if (ack_bit) begin
      bitcnt_reg <= 4'h0;
      ack_pend_reg <= 1'b0;
    end else if (bit_go) begin
      bitcnt_reg <= bitcnt_reg + 4'h1;
      shift_reg <= rx_byte;
      if (last_bit) begin
        ack_pend_reg <= ack_want;
      end
    end
  end

  // ---------------------------------------------------------------
  // Address counter and transmit byte
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      addr_reg <= '0;
      tx_reg <= 8'h00;
    end else begin
      if (take_word) begin
        addr_reg <= rx_byte;
      end else if (take_data && data_ok) begin
        addr_reg <= page_next;
      end else if (load_tx) begin
        addr_reg <= addr_reg + 1'b1;
      end
      if (load_tx) begin
        tx_reg <= mem_rd;
      end
    end
  end

  // ---------------------------------------------------------------
  // Page buffer
  // ---------------------------------------------------------------
  // Bytes land at any offset of the page and overwrite on wrap
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mask_reg <= '0;
      for (int i = 0; i < `SEP_PAGE_BYTES; i++) begin
        page_buf[i] <= 8'h00;
      end
    end else if (busy_reg && prog_cnt_reg == PROG_LAST) begin
      mask_reg <= '0;
    end else if (!busy_reg && (start_ev || take_word)) begin
      mask_reg <= '0;
    end else if (take_data && data_ok) begin
      page_buf[addr_reg[PW-1:0]] <= rx_byte;
      mask_reg[addr_reg[PW-1:0]] <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Self-timed program cycle
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      busy_reg <= 1'b0;
      prog_cnt_reg <= '0;
    end else if (prog_go) begin
      busy_reg <= 1'b1;
      prog_cnt_reg <= '0;
    end else if (busy_reg) begin
      busy_reg <= prog_cnt_reg != PROG_LAST;
      prog_cnt_reg <= prog_cnt_reg + 1'b1;
    end
  end

  // Array cells, erased at reset, filled from the page buffer
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < 2**AW; i++) begin
        mem[i] <= `SEP_ERASED;
      end
    end else if (commit_we) begin
      mem[commit_addr] <= page_buf[commit_idx];
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Data line only moves after a falling serial clock
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_sda_oe <= 1'b0;
      o_sda_o <= 1'b0;
      o_busy <= 1'b0;
    end else begin
      if (scl_fall) begin
        o_sda_oe <= drive_low;
      end
      o_sda_o <= 1'b0;
      o_busy <= busy_reg;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_oe_on_fall: assert property (@(posedge i_clk) disable iff (i_rst)
    $changed(o_sda_oe) |-> $past(scl_fall))
    else $error("data line moved without a clock fall");

  a_start_addr: assert property (@(posedge i_clk) disable iff (i_rst)
    start_ev && !stop_ev |=> state_reg == SEP_DEV_ADDR)
    else $error("start did not open address phase");

  a_stop_idle: assert property (@(posedge i_clk) disable iff (i_rst)
    stop_ev |=> state_reg == SEP_IDLE && !ack_pend_reg)
    else $error("stop did not return to idle");

  a_type_miss: assert property (@(posedge i_clk) disable iff (i_rst)
    take_dev && !type_ok |=> state_reg == SEP_IGNORE
      && !ack_pend_reg)
    else $error("wrong type code was acknowledged");

  a_sel_miss: assert property (@(posedge i_clk) disable iff (i_rst)
    take_dev && !sel_ok |=> !ack_pend_reg ##1 !ack_pend_reg)
    else $error("wrong select bits were acknowledged");

  a_addr_ack: assert property (@(posedge i_clk) disable iff (i_rst)
    take_dev && addr_hit |=> ack_pend_reg && state_reg ==
      ($past(dir_read) ? SEP_RD_DATA : SEP_WORD_ADDR))
    else $error("matching address not acknowledged");

  a_busy_nack: assert property (@(posedge i_clk) disable iff (i_rst)
    take_dev && busy_reg |=> !ack_pend_reg)
    else $error("address acknowledged while programming");

  a_page_wrap: assert property (@(posedge i_clk) disable iff (i_rst)
    take_data && data_ok |=>
      addr_reg[7:4] == $past(addr_reg[7:4]) &&
      addr_reg[3:0] == $past(addr_reg[3:0]) + 4'h1)
    else $error("page address left its page");

  a_wp_nack: assert property (@(posedge i_clk) disable iff (i_rst)
    take_data && wp_block |=> !ack_pend_reg
      && state_reg == SEP_IGNORE && mask_reg == $past(mask_reg))
    else $error("protected data byte was taken");

  a_prog_start: assert property (@(posedge i_clk) disable iff (i_rst)
    prog_go |=> busy_reg ##1 o_busy)
    else $error("program cycle did not start at stop");

  a_read_inc: assert property (@(posedge i_clk) disable iff (i_rst)
    load_tx |=> addr_reg == $past(addr_reg) + 8'h01
      && tx_reg == $past(mem_rd))
    else $error("read counter did not advance");

endmodule

// ===== sep_master_model.sv
// Two-wire bus master model that drives the serial clock and data pull.
// Assumes the bench resolves the open-drain data line into i_sda.
`timescale 1ns/100ps

module sep_master_model (
  // Resolved data line
  input wire logic i_sda,
  // Clock and data pull-down
  output logic o_scl,
  output logic o_sda_pull
);
  // Idle: clock stands high, data released to the pull-up
  initial begin
    o_scl = 1'b1;
    o_sda_pull = 1'b0;
  end

  // Start or repeated start: data falls while the clock is high
  task automatic start_cond();
    if (o_scl == 1'b0) begin
      o_sda_pull = 1'b0;
      #12 o_scl = 1'b1;
    end
    #12 o_sda_pull = 1'b1;
    #24 o_scl = 1'b0;
    #12;
  endtask

  // Stop: data rises while the clock is high, clock then stands still
  task automatic stop_cond();
    o_sda_pull = 1'b1;
    #12 o_scl = 1'b1;
    #24 o_sda_pull = 1'b0;
    #24;
  endtask

  // One bit out; data changes only in the low phase, so an idle high
  // clock is lowered first lest a data edge read as start or stop
  task automatic send_bit(input logic b);
    if (o_scl == 1'b1) begin
      #12 o_scl = 1'b0;
      #12;
    end
    o_sda_pull = ~b;
    #12 o_scl = 1'b1;
    #24 o_scl = 1'b0;
    #12;
  endtask

  // One bit in, sampled at the rising clock
  task automatic recv_bit(output logic b);
    o_sda_pull = 1'b0;
    #12 o_scl = 1'b1;
    b = i_sda;
    #24 o_scl = 1'b0;
    #12;
  endtask

  // Byte out MSB first, then the acknowledge slot
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      send_bit(d[i]);
    end
    recv_bit(b);
    ack = ~b;
  endtask

  // Byte in MSB first, then our acknowledge or its absence
  task automatic rd_byte(output logic [7:0] d, input logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      recv_bit(b);
      d[i] = b;
    end
    send_bit(~ack);
  endtask
endmodule

// ===== sep_core_bench.sv
// Self-checking bench of the serial memory slave against a byte model.
// Assumes the master model file and the design files are compiled first.
`timescale 1ns/100ps

module sep_core_bench;
  localparam int PROG = 400;
  // Device type code, value arbitrary
  localparam logic [3:0] TYPE = 4'h5;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic wp = 1'b0;
  logic [2:0] strap = 3'h0;
  logic scl, pull, sda, o_sda_o, o_sda_oe, o_busy, ack;
  logic [7:0] d, a;
  integer seed = 32'hd5f3;
  int err_count = 0;
  int samples_checked = 0;
  int mem [256];
  int cnt, run = 0, busy_len = 0;

  // System clock and open-drain resolution with pull-up
  always #2.5 i_clk = ~i_clk;
  assign sda = ~(o_sda_oe | pull);

  sep_core #(.PROG_CYCLES(PROG), .TYPE_CODE(TYPE)) u_sep_core (
    .i_clk(i_clk), .i_rst(i_rst), .i_scl(scl), .i_sda(sda),
    .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe),
    .i_select_strap_bit0(strap[0]), .i_select_strap_bit1(strap[1]),
    .i_select_strap_bit2(strap[2]), .i_wp(wp), .o_busy(o_busy));

  sep_master_model u_sep_master_model (
    .i_sda(sda), .o_scl(scl), .o_sda_pull(pull));

  // Length of each busy span in system clocks
  always @(posedge i_clk) begin
    if (o_busy === 1'b1) begin
      run <= run + 1;
    end else if (run != 0) begin
      busy_len <= run;
      run <= 0;
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  function automatic logic [7:0] sa(input logic rd);
    return {TYPE, strap, rd};
  endfunction

  // Start, write-direction address, word address
  task automatic addr_phase(input logic [7:0] wa);
    u_sep_master_model.start_cond();
    u_sep_master_model.wr_byte(sa(1'b0), ack);
    chk(ack, 1);
    u_sep_master_model.wr_byte(wa, ack);
    chk(ack, 1);
  endtask

  // Master reads n bytes, acknowledging all but the last
  task automatic rd_seq(input int n);
    for (int i = 0; i < n; i++) begin
      u_sep_master_model.rd_byte(d, i < n - 1);
      chk(d, mem[cnt][7:0]);
      cnt = (cnt + 1) % 256;
    end
    u_sep_master_model.stop_cond();
    chk(o_sda_oe, 0);
  endtask

  task automatic rand_read(input logic [7:0] ra, input int n);
    addr_phase(ra);
    u_sep_master_model.start_cond();
    u_sep_master_model.wr_byte(sa(1'b1), ack);
    chk(ack, 1);
    cnt = ra;
    rd_seq(n);
  endtask

  task automatic cur_read(input int n);
    u_sep_master_model.start_cond();
    u_sep_master_model.wr_byte(sa(1'b1), ack);
    chk(ack, 1);
    rd_seq(n);
  endtask

  // Write n random bytes; the model commits them at stop
  task automatic do_write(input logic [7:0] wa, input int n,
                          input logic prot);
    logic [7:0] q [$];
    addr_phase(wa);
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      u_sep_master_model.wr_byte(d, ack);
      chk(ack, !prot);
      q.push_back(d);
    end
    u_sep_master_model.stop_cond();
    if (!prot) begin
      foreach (q[i]) mem[{wa[7:4], wa[3:0] + i[3:0]}] = q[i];
      cnt = {wa[7:4], wa[3:0] + n[3:0]};
    end
    repeat (12) @(posedge i_clk);
    chk(o_busy, !prot);
    chk(o_sda_oe, 0);
    if (!prot) begin
      u_sep_master_model.start_cond();
      u_sep_master_model.wr_byte(sa(1'b0), ack);
      chk(ack, 0);
      u_sep_master_model.stop_cond();
      for (int i = 0; i < 2 * PROG && o_busy !== 1'b0; i++) begin
        @(posedge i_clk);
      end
      repeat (2) @(posedge i_clk);
      chk(busy_len, PROG);
    end
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    #200000;
    err_count++;
    wrap_up();
  end

  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'hff;
    strap = 3'($random(seed));
    repeat (16) @(posedge i_clk);
    #1 i_rst = 1'b0;
    chk(o_busy, 0);
    chk(o_sda_oe, 0);
    repeat (8) @(posedge i_clk);
    // A byte with no start before it is ignored
    u_sep_master_model.wr_byte(sa(1'b0), ack);
    chk(ack, 0);
    u_sep_master_model.stop_cond();
    // Wrong type code, then each select bit flipped
    for (int i = 0; i < 4; i++) begin
      u_sep_master_model.start_cond();
      u_sep_master_model.wr_byte(sa(1'b0) ^ ((i == 0) ? 8'h80 : 8'h01 << i),
                                 ack);
      chk(ack, 0);
      u_sep_master_model.stop_cond();
    end
    // Byte write and read back
    a = 8'($random(seed)) & 8'h7f;
    do_write(a, 1, 1'b0);
    rand_read(a, 1);
    // Page write from inside a page, eighteen bytes wrap over the start
    a[3:0] = 4'hd;
    do_write(a, 18, 1'b0);
    cur_read(1);
    rand_read({a[7:4], 4'h0}, 16);
    // Sequential read across the top of the array
    rand_read(8'hfc, 6);
    // Protected upper half refuses data, lower half still writable
    @(posedge i_clk);
    #1 wp = 1'b1;
    repeat (4) @(posedge i_clk);
    a[7] = 1'b1;
    do_write(a, 1, 1'b1);
    a[7] = 1'b0;
    do_write(a, 1, 1'b0);
    rand_read({1'b1, a[6:0]}, 1);
    rand_read(a, 1);
    wrap_up();
  end
endmodule
